// File: adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model #(
	parameter int TICKS = 6
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// control from the sequencer
	input  adc_seq_pkg::core_ctl_type  core_ctl,
	// level that the bench wants converted
	input  wire logic [11:0]           sample,
	// result to the sequencer
	output logic                       core_done,
	output logic [11:0]                core_data
);
	logic running;
	int   left;

	// ************************************************************
	// conversion timing: a fixed number of divider ticks
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= 1'b0;
			left <= 0;
			core_done <= 1'b0;
			core_data <= 12'h000;
		end else begin
			core_done <= 1'b0;
			// data is only meaningful with done, so it is inverted every cycle in between
			core_data <= ~core_data;
			if (!core_ctl.enable) begin
				running <= 1'b0;
			end else if (core_ctl.start) begin
				running <= 1'b1;
				left <= TICKS;
			end else if (running && core_ctl.tick) begin
				left <= left - 1;
				if (left == 1) begin
					running <= 1'b0;
					core_done <= 1'b1;
					core_data <= sample;
				end
			end
		end
	end
endmodule

// File: adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// byte offsets on the register bus
`define OFS_MAIN_CONTROL   8'h00
`define OFS_SOURCE_CLOCK   8'h04
`define OFS_REFERENCE_CTRL 8'h08
`define OFS_BANDGAP_CTRL   8'h0c
`define OFS_RESULT_LOW     8'h10
`define OFS_RESULT_HIGH    8'h14
`define OFS_IRQ_STATUS     8'h18
`define OFS_IRQ_MASK       8'h1c

// adc_main_control fields
`define BIT_START          7
`define BIT_BUSY           6
`define BIT_ENABLE         5
`define BIT_ALIGN          4
`define CH_HI              3

// adc_source_clock_select fields
`define SRC_HI             7
`define SRC_LO             4
`define DIV_HI             2

// writable masks (reserved bits read zero)
`define MASK_SOURCE_CLOCK  8'hf7
`define MASK_REFERENCE     8'h9f
`define MASK_MAIN_WRITE    8'hbf

// reference control fields
`define BIT_AMP_EN         7
`define BIT_AMP_IN         4
`define REF_HI             3
`define REF_LO             2
`define GAIN_HI            1

// channel map
`define FIRST_CHANNEL      4'h3
`define LAST_CHANNEL       4'h7
`define NUM_CHANNELS       5

// reset values
`define RST_BYTE           8'h00
`define RST_RESULT         12'h000
`define RST_WORD           32'h0000_0000

`endif

// File: adc_seq_pkg.sv
package adc_seq_pkg;

	typedef enum logic {
		conv_idle,
		conv_run
	} conv_state_type;

	typedef struct packed {
		logic [7:0]     main_ctl;
		logic [7:0]     src_clk;
		logic [7:0]     ref_ctl;
		logic           bandgap_en;
		conv_state_type conv;
		logic [11:0]    result;
		logic           irq_status;
		logic           irq_mask;
		logic           irq;
		logic [6:0]     div_cnt;
		logic           div_tick;
		logic           conv_start;
		logic [4:0]     ext_onehot;
		logic [4:0]     pin_override;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
	} state_type;

	typedef struct packed {
		logic        enable;
		logic        start;
		logic        tick;
		logic [3:0]  source;
		logic [4:0]  channel_onehot;
		logic        amp_enable;
		logic        amp_input;
		logic [1:0]  ref_source;
		logic [1:0]  amp_gain;
		logic        bandgap_enable;
	} core_ctl_type;

endpackage

// File: adc_sequencer_regs.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_sequencer_regs (
	// clock, reset, enable
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// interrupt
	output logic                           irq,
	// converter core
	input  wire logic                      core_done,
	input  wire logic [11:0]               core_data,
	output adc_seq_pkg::core_ctl_type      core_ctl,
	// pin function
	input  wire logic [`NUM_CHANNELS-1:0]  pin_func_analog,
	output logic      [`NUM_CHANNELS-1:0]  pin_override
);

	adc_seq_pkg::state_type s_q;
	adc_seq_pkg::state_type s_d;

	logic       setup_ph;
	logic       write_acc;
	logic       launch;
	logic       src_external;
	logic [6:0] div_limit;
	logic [7:0] res_low;
	logic [7:0] res_high;
	logic [7:0] wbyte;
	logic [3:0] ch_code;

	// ************************************************************
	// bus phases and result formatting
	// ************************************************************

	assign setup_ph  = psel & ~penable;
	assign write_acc = psel & penable & pwrite & s_q.pready;
	assign wbyte     = pwdata[7:0];
	assign ch_code   = s_q.main_ctl[`CH_HI:0];

	// the launch is seen on the write that clears a stored start bit
	assign launch = write_acc && (paddr == `OFS_MAIN_CONTROL) && s_q.main_ctl[`BIT_START] &&
		!wbyte[`BIT_START] && wbyte[`BIT_ENABLE] && (s_q.conv == adc_seq_pkg::conv_idle);

	// source codes 0000, 0100 and 11xx go to the pins
	assign src_external = (s_q.src_clk[`SRC_HI:`SRC_LO] == 4'h0) ||
		(s_q.src_clk[`SRC_HI:`SRC_LO] == 4'h4) || (s_q.src_clk[`SRC_HI:`SRC_HI-1] == 2'h3);

	assign div_limit = 7'(({1'b0, 7'h01} << s_q.src_clk[`DIV_HI:0]) - 8'h01);

	always_comb begin
		if (s_q.main_ctl[`BIT_ALIGN]) begin
			res_high = {4'h0, s_q.result[11:8]};
			res_low  = s_q.result[7:0];
		end else begin
			res_high = s_q.result[11:4];
			res_low  = {s_q.result[3:0], 4'h0};
		end
	end

	// ************************************************************
	// next state
	// ************************************************************

	always_comb begin
		s_d = s_q;
		s_d.conv_start = 1'b0;
		s_d.pready     = 1'b0;
		s_d.pslverr    = 1'b0;

		// register writes take effect at the access edge only
		if (write_acc) begin
			case (paddr)
				`OFS_MAIN_CONTROL: begin
					// busy is read only: the written busy bit is masked off and never stored
					s_d.main_ctl = wbyte & `MASK_MAIN_WRITE;
				end
				`OFS_SOURCE_CLOCK: begin
					s_d.src_clk = wbyte & `MASK_SOURCE_CLOCK;
				end
				`OFS_REFERENCE_CTRL: begin
					s_d.ref_ctl = wbyte & `MASK_REFERENCE;
				end
				`OFS_BANDGAP_CTRL: begin
					s_d.bandgap_en = wbyte[0];
				end
				`OFS_IRQ_STATUS: begin
					if (wbyte[0]) begin
						s_d.irq_status = 1'b0;
					end
				end
				`OFS_IRQ_MASK: begin
					s_d.irq_mask = wbyte[0];
				end
				default: begin
				end
			endcase
		end

		// conversion sequencing
		case (s_q.conv)
			adc_seq_pkg::conv_idle: begin
				if (launch) begin
					s_d.conv       = adc_seq_pkg::conv_run;
					s_d.conv_start = 1'b1;
				end
			end
			adc_seq_pkg::conv_run: begin
				if (!s_q.main_ctl[`BIT_ENABLE]) begin
					// power-down aborts; results are left as they were
					s_d.conv = adc_seq_pkg::conv_idle;
				end else if (core_done) begin
					s_d.result     = core_data;
					s_d.conv       = adc_seq_pkg::conv_idle;
					s_d.irq_status = 1'b1; // set wins over a same-cycle clear
				end
			end
			default: begin
				s_d.conv = adc_seq_pkg::conv_idle;
			end
		endcase

		// conversion clock divider, halted while powered down
		s_d.div_tick = 1'b0;
		if (!s_q.main_ctl[`BIT_ENABLE]) begin
			s_d.div_cnt = 7'h00;
		end else if (s_q.div_cnt >= div_limit) begin
			s_d.div_cnt  = 7'h00;
			s_d.div_tick = 1'b1;
		end else begin
			s_d.div_cnt = 7'(s_q.div_cnt + 7'h01);
		end

		// external channel switch
		for (int i = 0; i < `NUM_CHANNELS; i++) begin
			s_d.ext_onehot[i] = s_q.main_ctl[`BIT_ENABLE] && src_external &&
				(ch_code == 4'(`FIRST_CHANNEL + i));
		end

		s_d.pin_override = pin_func_analog;
		s_d.irq          = (s_d.irq_status & s_d.irq_mask);

		// read data captured in the setup cycle, answered next cycle
		if (setup_ph) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = 1'b0;
			s_d.prdata  = `RST_WORD;
			case (paddr)
				`OFS_MAIN_CONTROL: begin
					s_d.prdata[7:0] = s_q.main_ctl;
					s_d.prdata[`BIT_BUSY] = (s_q.conv == adc_seq_pkg::conv_run);
				end
				`OFS_SOURCE_CLOCK: begin
					s_d.prdata[7:0] = s_q.src_clk;
				end
				`OFS_REFERENCE_CTRL: begin
					s_d.prdata[7:0] = s_q.ref_ctl;
				end
				`OFS_BANDGAP_CTRL: begin
					s_d.prdata[0] = s_q.bandgap_en;
				end
				`OFS_RESULT_LOW: begin
					s_d.prdata[7:0] = res_low;
				end
				`OFS_RESULT_HIGH: begin
					s_d.prdata[7:0] = res_high;
				end
				`OFS_IRQ_STATUS: begin
					s_d.prdata[0] = s_q.irq_status;
				end
				`OFS_IRQ_MASK: begin
					s_d.prdata[0] = s_q.irq_mask;
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.main_ctl     <= `RST_BYTE;
			s_q.src_clk      <= `RST_BYTE;
			s_q.ref_ctl      <= `RST_BYTE;
			s_q.bandgap_en   <= 1'b0;
			s_q.conv         <= adc_seq_pkg::conv_idle;
			s_q.result       <= `RST_RESULT;
			s_q.irq_status   <= 1'b0;
			s_q.irq_mask     <= 1'b0;
			s_q.irq          <= 1'b0;
			s_q.div_cnt      <= 7'h00;
			s_q.div_tick     <= 1'b0;
			s_q.conv_start   <= 1'b0;
			s_q.ext_onehot   <= 5'h00;
			s_q.pin_override <= 5'h00;
			s_q.prdata       <= `RST_WORD;
			s_q.pready       <= 1'b0;
			s_q.pslverr      <= 1'b0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************

	assign prdata                 = s_q.prdata;
	assign pready                 = s_q.pready;
	assign pslverr                = s_q.pslverr;
	assign irq                    = s_q.irq;
	assign pin_override           = s_q.pin_override;
	assign core_ctl.enable        = s_q.main_ctl[`BIT_ENABLE];
	assign core_ctl.start         = s_q.conv_start;
	assign core_ctl.tick          = s_q.div_tick;
	assign core_ctl.source        = s_q.src_clk[`SRC_HI:`SRC_LO];
	assign core_ctl.channel_onehot = s_q.ext_onehot;
	assign core_ctl.amp_enable    = s_q.ref_ctl[`BIT_AMP_EN];
	assign core_ctl.amp_input     = s_q.ref_ctl[`BIT_AMP_IN];
	assign core_ctl.ref_source    = s_q.ref_ctl[`REF_HI:`REF_LO];
	assign core_ctl.amp_gain      = s_q.ref_ctl[`GAIN_HI:0];
	assign core_ctl.bandgap_enable = s_q.bandgap_en;

	// ************************************************************
	// checks
	// ************************************************************

	busy_on_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && launch) |=> (s_q.conv == adc_seq_pkg::conv_run) && s_q.conv_start)
		else $error("busy flag not raised at launch");

	start_falling_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_q.conv_start) |-> $past(s_q.main_ctl[`BIT_START], 2) && !s_q.main_ctl[`BIT_START])
		else $error("launch without a high-then-low start bit");

	done_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && s_q.conv == adc_seq_pkg::conv_run && s_q.main_ctl[`BIT_ENABLE] && core_done)
		|=> (s_q.conv == adc_seq_pkg::conv_idle) && (s_q.result == $past(core_data)))
		else $error("result and busy not updated together");

	disabled_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!s_q.main_ctl[`BIT_ENABLE] |=> $stable(s_q.result))
		else $error("result changed while disabled");

	power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !s_q.main_ctl[`BIT_ENABLE] && !launch) |=> (s_q.conv == adc_seq_pkg::conv_idle))
		else $error("conversion runs while disabled");

	align_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && setup_ph && paddr == `OFS_RESULT_LOW && !s_q.main_ctl[`BIT_ALIGN])
		|=> s_q.prdata == {20'h00000, $past(s_q.result[3:0]), 8'h00} >> 4)
		else $error("left-aligned low byte wrong");

	align_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && setup_ph && paddr == `OFS_RESULT_HIGH && s_q.main_ctl[`BIT_ALIGN])
		|=> s_q.prdata == {28'h0000000, $past(s_q.result[11:8])})
		else $error("right-aligned high byte wrong");

	upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.pready |-> (s_q.prdata[31:8] == 24'h000000))
		else $error("unused read bits not zero");

	internal_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !src_external) |=> (s_q.ext_onehot == 5'h00))
		else $error("external channel connected with internal source");

	channel_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && src_external && s_q.main_ctl[`BIT_ENABLE] && ch_code == `LAST_CHANNEL) |=> (s_q.ext_onehot == 5'h10))
		else $error("channel seven not selected");

	divider_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && s_q.div_tick && div_limit != 7'h00)
		|=> !s_q.div_tick)
		else $error("divider tick too frequent");

	pin_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> (pin_override == $past(pin_func_analog)))
		else $error("pin override does not follow selection");

	pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && s_q.pready) |=> !s_q.pready)
		else $error("ready held longer than one cycle");

	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && setup_ph && paddr > `OFS_IRQ_MASK) |=> (pslverr && pready))
		else $error("unmapped access without error");

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq == (s_q.irq_status & s_q.irq_mask))
		else $error("interrupt level does not follow status and mask");

	done_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && s_q.conv == adc_seq_pkg::conv_run && s_q.main_ctl[`BIT_ENABLE] && core_done) |=> s_q.irq_status)
		else $error("completion did not set the status bit");

	start_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && s_q.conv_start) |=> !s_q.conv_start)
		else $error("start pulse longer than one cycle");

	busy_readonly_a: assert property (@(posedge pclk) disable iff (!presetn)
		!s_q.main_ctl[`BIT_BUSY])
		else $error("busy bit stored from a write");

	reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		((s_q.src_clk & ~`MASK_SOURCE_CLOCK) == 8'h00) && ((s_q.ref_ctl & ~`MASK_REFERENCE) == 8'h00))
		else $error("reserved control bit set");

	tick_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !s_q.main_ctl[`BIT_ENABLE]) |=> !s_q.div_tick)
		else $error("divider ticks while powered down");

endmodule

// File: tb.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module tb;
	logic                      pclk;
	logic                      presetn;
	logic                      ce;
	logic                      psel;
	logic                      penable;
	logic                      pwrite;
	logic [7:0]                paddr;
	logic [31:0]               pwdata;
	logic [31:0]               prdata;
	logic                      pready;
	logic                      pslverr;
	logic                      irq;
	logic                      core_done;
	logic [11:0]               core_data;
	logic [11:0]               sample;
	logic [4:0]                pin_func_analog;
	logic [4:0]                pin_override;
	adc_seq_pkg::core_ctl_type core_ctl;
	logic [31:0]               rd;
	logic                      err;
	int                        mismatches = 0;
	int                        n_tests = 0;
	int                        cycles = 0;
	int                        gap_cnt = 0;
	int                        last_gap = 0;
	int                        starts = 0;
	logic [7:0]                ofs [3] = '{`OFS_SOURCE_CLOCK, `OFS_REFERENCE_CTRL, `OFS_BANDGAP_CTRL};
	logic [7:0]                msk [3] = '{`MASK_SOURCE_CLOCK, `MASK_REFERENCE, 8'h01};

	adc_sequencer_regs dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .core_done(core_done), .core_data(core_data), .core_ctl(core_ctl),
		.pin_func_analog(pin_func_analog), .pin_override(pin_override));
	adc_core_model #(.TICKS(6)) core (.pclk(pclk), .presetn(presetn), .core_ctl(core_ctl), .sample(sample),
		.core_done(core_done), .core_data(core_data));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ************************************************************
	// bus tasks and comparison
	// ************************************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one idle cycle follows each transfer so psel is never assigned twice at one edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		check(nm, rd, exp);
	endtask

	task automatic launch(input logic [7:0] ctl);
		wr(`OFS_MAIN_CONTROL, {24'h000000, ctl | 8'h80});
		wr(`OFS_MAIN_CONTROL, {24'h000000, ctl});
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 200; i++) begin
			xfer(1'b0, `OFS_MAIN_CONTROL, 32'h0000_0000);
			if (rd[`BIT_BUSY] === 1'b0) break;
		end
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (core_ctl.start === 1'b1) begin
			starts <= starts + 1;
		end
		if (core_ctl.tick === 1'b1) begin
			last_gap <= gap_cnt;
			gap_cnt <= 1;
		end else begin
			gap_cnt <= gap_cnt + 1;
		end
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		sample = 12'habc;
		pin_func_analog = 5'h00;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk("main_ctl", `OFS_MAIN_CONTROL, 32'h0);
		rd_chk("result_high", `OFS_RESULT_HIGH, 32'h0);
		foreach (ofs[i]) begin
			rd_chk("reset_val", ofs[i], 32'h0);
			wr(ofs[i], 32'h0000_00ff);
			rd_chk("rw_mask", ofs[i], {24'h0, msk[i]});
			wr(ofs[i], 32'h0);
		end
		wr(`OFS_REFERENCE_CTRL, 32'h0000_0095);
		wr(`OFS_BANDGAP_CTRL, 32'h0000_0001);
		check("core_ref", {25'h0, core_ctl.amp_enable, core_ctl.amp_input, core_ctl.ref_source, core_ctl.amp_gain,
			core_ctl.bandgap_enable}, 32'h6b);
		xfer(1'b0, 8'h20, 32'h0);
		check("unmapped_err", {31'h0, err}, 32'h1);
		wr(`OFS_RESULT_LOW, 32'h0000_00ff);
		rd_chk("result_low_ro", `OFS_RESULT_LOW, 32'h0);
		wr(`OFS_MAIN_CONTROL, 32'h0000_0060);
		rd_chk("busy_ro", `OFS_MAIN_CONTROL, 32'h20);
		wr(`OFS_MAIN_CONTROL, 32'h0000_0020);
		rd_chk("no_launch", `OFS_MAIN_CONTROL, 32'h20);
		for (int c = 0; c < 16; c++) begin
			wr(`OFS_MAIN_CONTROL, 32'h20 | c);
			repeat (2) @(posedge pclk);
			check("ch_onehot", {27'h0, core_ctl.channel_onehot}, (c >= 3 && c <= 7) ? 1 << (c - 3) : 0);
		end
		wr(`OFS_MAIN_CONTROL, 32'h23);
		for (int s = 0; s < 16; s++) begin
			wr(`OFS_SOURCE_CLOCK, s << 4);
			repeat (2) @(posedge pclk);
			check("src", {28'h0, core_ctl.source}, s);
			check("src_ext", {27'h0, core_ctl.channel_onehot}, (s == 0 || s == 4 || s >= 12) ? 1 : 0);
		end
		wr(`OFS_SOURCE_CLOCK, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h1);
		launch(8'h23);
		rd_chk("busy_set", `OFS_MAIN_CONTROL, 32'h63);
		wait_idle();
		rd_chk("align0_high", `OFS_RESULT_HIGH, 32'hab);
		rd_chk("align0_low", `OFS_RESULT_LOW, 32'hc0);
		check("irq_on", {31'h0, irq}, 32'h1);
		wr(`OFS_IRQ_STATUS, 32'h1);
		rd_chk("irq_clr", `OFS_IRQ_STATUS, 32'h0);
		check("irq_off", {31'h0, irq}, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h0);
		sample = 12'h5a3;
		launch(8'h37);
		wait_idle();
		rd_chk("align1_high", `OFS_RESULT_HIGH, 32'h05);
		rd_chk("align1_low", `OFS_RESULT_LOW, 32'ha3);
		check("irq_masked", {31'h0, irq}, 32'h0);
		rd_chk("irq_pending", `OFS_IRQ_STATUS, 32'h1);
		wr(`OFS_IRQ_STATUS, 32'h1);
		sample = 12'h111;
		launch(8'h10);
		check("core_off", {31'h0, core_ctl.enable}, 32'h0);
		rd_chk("off_idle", `OFS_MAIN_CONTROL, 32'h10);
		rd_chk("kept_high", `OFS_RESULT_HIGH, 32'h05);
		wr(`OFS_SOURCE_CLOCK, 32'h3);
		sample = 12'h222;
		launch(8'h37);
		repeat (30) @(posedge pclk);
		check("tick_gap", last_gap, 32'h8);
		wr(`OFS_MAIN_CONTROL, 32'h17);
		rd_chk("abort_idle", `OFS_MAIN_CONTROL, 32'h17);
		rd_chk("abort_low", `OFS_RESULT_LOW, 32'ha3);
		pin_func_analog <= 5'b10110;
		repeat (3) @(posedge pclk);
		check("pin_override", {27'h0, pin_override}, 32'h16);
		ce <= 1'b0;
		pin_func_analog <= 5'b01001;
		repeat (3) @(posedge pclk);
		check("ce_freeze", {27'h0, pin_override}, 32'h16);
		ce <= 1'b1;
		repeat (3) @(posedge pclk);
		check("ce_resume", {27'h0, pin_override}, 32'h09);
		check("start_pulses", starts, 32'h3);
		tally_and_finish();
	end
endmodule
